// file: verilog/eil_pkg.sv
// package for the encoder index event latch: register map, field layout, constants
// assumes apb byte addresses of four times the register index
package eil_pkg;
    // ==========================================
    // register map (indices, byte address = 4 * index)
    localparam logic [5:0] EIL_IDX_CFG = 6'h38;
    localparam logic [5:0] EIL_IDX_CNT = 6'h39;
    localparam logic [5:0] EIL_IDX_CONST = 6'h3a;
    localparam logic [5:0] EIL_IDX_STS = 6'h3b;
    localparam logic [5:0] EIL_IDX_LATCH = 6'h3c;
    localparam logic [5:0] EIL_IDX_MASK = 6'h3e;
    localparam logic [5:0] EIL_IDX_XLATCH = 6'h3f;
    localparam int unsigned EIL_AW = 8;
    // ==========================================
    // encoder_config fields
    localparam int unsigned EIL_CFG_W = 11;
    localparam int unsigned EIL_B_DEC = 10;
    localparam int unsigned EIL_B_LXA = 9;
    localparam int unsigned EIL_B_CLR = 8;
    localparam int unsigned EIL_B_NEG = 7;
    localparam int unsigned EIL_B_POS = 6;
    localparam int unsigned EIL_B_ONCE = 5;
    localparam int unsigned EIL_B_CONT = 4;
    localparam int unsigned EIL_B_SKIP = 3;
    localparam int unsigned EIL_B_PN = 2;
    localparam int unsigned EIL_B_PB = 1;
    localparam int unsigned EIL_B_PA = 0;
    localparam int unsigned EIL_B_STS_EV = 0;
    // ==========================================
    // reset values and divisors
    localparam logic [10:0] EIL_CFG_RST = 11'h000;
    localparam logic [31:0] EIL_CONST_RST = 32'h0001_0000;
    localparam logic [16:0] EIL_DIV_BIN = 17'h1_0000;
    localparam logic [16:0] EIL_DIV_DEC = 17'h0_2710;
    // sensitivity codes {neg, pos}
    typedef enum logic [1:0] {EIL_SENS_LVL, EIL_SENS_ACT, EIL_SENS_INACT, EIL_SENS_BOTH} eil_sens_t;
endpackage

// file: verilog/eil_pins_if.sv
// interface carrying synchronised encoder levels and their previous values
// assumes bit 0 = a, bit 1 = b, bit 2 = index
`timescale 1ns/1ps
`default_nettype none
interface eil_pins_if;
    logic [2:0] lvl;
    logic [2:0] prv;
    modport src (output lvl, output prv);
    modport dst (input lvl, input prv);
endinterface
`default_nettype wire

// file: verilog/eil_sync.sv
// two-flop synchroniser with one history stage for the encoder pins
// assumes pins are sampled by pclk only
`timescale 1ns/1ps
`default_nettype none
module eil_sync
    import eil_pkg::*;
#(
    parameter int unsigned W = 3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] raw,
    eil_pins_if.src pins
);
    // ==========================================
    // synchroniser stages
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign pins.lvl = s2_r;
    assign pins.prv = s3_r;
endmodule
`default_nettype wire

// file: verilog/eil_top.sv
// encoder index event latch with quadrature counter and apb register slave
// assumes one 20 MHz clock pclk and asynchronous active-low presetn
//
// Notes on behaviour
// - divisor bit 0: fraction of accumulation constant counts modulo 65536
// - divisor bit 1: fraction of accumulation constant counts modulo 10000
// - bit 9: also capture ramp position on a qualified index event
// - bit 8 low: event copies count into latch, counter untouched
// - bit 8 high: event copies count into latch, then clears counter
// - bits 7..6 pick level, active edge, inactive edge or both edges
// - bit 5: latch only on the first event after the register write
// - bit 4: latch on every qualified event
// - bit 3 low: index, a and b must all match their polarities
// - bit 3 high: a and b ignored for index qualification
// - bit 2 sets active level of index: 0 low, 1 high
// - bit 1 gives required b level
// - bit 0 gives required a level
// - latch register holds last latched count, read only
// - event sets sticky flag, anded with mask bit into interrupt, write 1 clears
`timescale 1ns/1ps
`default_nettype none
module eil_top
    import eil_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [EIL_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_n,
    input wire logic [31:0] ramp_actual_position,
    output logic enc_irq
);
    // ==========================================
    // pin conditioning
    eil_pins_if pins ();

    eil_sync #(.W(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .raw({enc_n, enc_b, enc_a}),
        .pins(pins)
    );

    logic [EIL_CFG_W-1:0] cfg_r;
    logic [31:0] cnt_r;
    logic [15:0] frac_r;
    logic [31:0] const_r;
    logic [31:0] latch_r;
    logic [31:0] xlat_r;
    logic sts_r;
    logic mask_r;
    logic once_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;

    // ==========================================
    // apb decode
    wire [5:0] idx = paddr[7:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready_r;
    wire wr = acc & pwrite;
    wire hit_cfg = aligned & (idx == EIL_IDX_CFG);
    wire hit_cnt = aligned & (idx == EIL_IDX_CNT);
    wire hit_const = aligned & (idx == EIL_IDX_CONST);
    wire hit_sts = aligned & (idx == EIL_IDX_STS);
    wire hit_latch = aligned & (idx == EIL_IDX_LATCH);
    wire hit_mask = aligned & (idx == EIL_IDX_MASK);
    wire hit_xlat = aligned & (idx == EIL_IDX_XLATCH);
    wire mapped = hit_cfg | hit_cnt | hit_const | hit_sts | hit_latch | hit_mask | hit_xlat;
    wire wr_cfg = wr & hit_cfg;
    wire wr_cnt = wr & hit_cnt;
    wire wr_const = wr & hit_const;
    wire wr_sts = wr & hit_sts;
    wire wr_mask = wr & hit_mask;
    wire [31:0] rd_val = hit_cfg ? {21'h0, cfg_r} :
                         hit_cnt ? cnt_r :
                         hit_sts ? {31'h0, sts_r} :
                         hit_latch ? latch_r :
                         hit_mask ? {31'h0, mask_r} :
                         hit_xlat ? xlat_r : 32'h0;

    // ==========================================
    // quadrature decode and accumulation
    wire a = pins.lvl[0];
    wire b = pins.lvl[1];
    wire ap = pins.prv[0];
    wire bp = pins.prv[1];
    wire step = (a ^ ap) ^ (b ^ bp);
    wire up = a ^ bp;
    wire [16:0] div = cfg_r[EIL_B_DEC] ? EIL_DIV_DEC : EIL_DIV_BIN;
    wire [16:0] cf = {1'b0, const_r[15:0]};
    wire [31:0] ci = {{16{const_r[31]}}, const_r[31:16]};
    wire [16:0] f_up = {1'b0, frac_r} + cf;
    wire f_cy = (f_up >= div);
    wire [16:0] f_up_n = f_cy ? f_up - div : f_up;
    wire [16:0] f_dn = {1'b0, frac_r} - cf;
    wire f_bw = f_dn[16];
    wire [16:0] f_dn_n = f_bw ? f_dn + div : f_dn;
    wire [31:0] cnt_up = cnt_r + ci + {31'h0, f_cy};
    wire [31:0] cnt_dn = cnt_r - ci - {31'h0, f_bw};

    // ==========================================
    // index qualification and event detection
    wire n_act = (pins.lvl[2] == cfg_r[EIL_B_PN]);
    wire n_actp = (pins.prv[2] == cfg_r[EIL_B_PN]);
    wire ab_ok = cfg_r[EIL_B_SKIP] | ((a == cfg_r[EIL_B_PA]) & (b == cfg_r[EIL_B_PB]));
    wire ab_okp = cfg_r[EIL_B_SKIP] | ((ap == cfg_r[EIL_B_PA]) & (bp == cfg_r[EIL_B_PB]));
    wire q = n_act & ab_ok;
    wire qp = n_actp & ab_okp;
    wire [1:0] sens = {cfg_r[EIL_B_NEG], cfg_r[EIL_B_POS]};
    wire n_ev = (sens == EIL_SENS_LVL) ? q :
                (sens == EIL_SENS_ACT) ? (q & ~qp) :
                (sens == EIL_SENS_INACT) ? (~q & qp) : (q ^ qp);
    wire take = n_ev & (cfg_r[EIL_B_CONT] | once_r);
    wire sts_nxt = n_ev | (sts_r & ~(wr_sts & pwdata[EIL_B_STS_EV]));
    wire mask_nxt = wr_mask ? pwdata[0] : mask_r;

    // ==========================================
    // configuration and one-shot arm
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r <= EIL_CFG_RST;
            const_r <= EIL_CONST_RST;
            once_r <= 1'b0;
            mask_r <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
                cfg_r <= pwdata[EIL_CFG_W-1:0];
            if (wr_const)
                const_r <= pwdata;
            if (wr_cfg)
                once_r <= pwdata[EIL_B_ONCE];
            else if (take)
                once_r <= 1'b0;
            mask_r <= mask_nxt;
        end
    end

    // ==========================================
    // encoder counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 32'h0;
            frac_r <= 16'h0;
        end
        else if (take & cfg_r[EIL_B_CLR])
        begin
            cnt_r <= 32'h0;
            frac_r <= 16'h0;
        end
        else if (wr_cnt)
        begin
            cnt_r <= pwdata;
            frac_r <= 16'h0;
        end
        else if (step)
        begin
            cnt_r <= up ? cnt_up : cnt_dn;
            frac_r <= up ? f_up_n[15:0] : f_dn_n[15:0];
        end
    end

    // ==========================================
    // latches, status, interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch_r <= 32'h0;
            xlat_r <= 32'h0;
            sts_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            if (take)
                latch_r <= cnt_r;
            if (take & cfg_r[EIL_B_LXA])
                xlat_r <= ramp_actual_position;
            sts_r <= sts_nxt;
            irq_r <= sts_nxt & mask_nxt;
        end
    end

    // ==========================================
    // apb response
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
            if (setup & ~pwrite)
                prdata_r <= rd_val;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign enc_irq = irq_r;

    // ==========================================
    // assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_latch_copy: assert property (take |=> latch_r == $past(cnt_r))
        else $error("latch does not hold count at event");
    chk_clear_count: assert property (take && cfg_r[EIL_B_CLR] |=> cnt_r == 32'h0)
        else $error("counter not cleared on event");
    chk_keep_count: assert property (take && !cfg_r[EIL_B_CLR] && !step && !wr_cnt
        |=> cnt_r == $past(cnt_r))
        else $error("counter changed without clear");
    chk_ramp_latch: assert property (take && cfg_r[EIL_B_LXA]
        |=> xlat_r == $past(ramp_actual_position))
        else $error("ramp position not latched");
    chk_once_drop: assert property (take && !wr_cfg |=> !once_r)
        else $error("one-shot still armed after event");
    chk_cont_take: assert property (n_ev && cfg_r[EIL_B_CONT] |-> take)
        else $error("continuous mode missed event");
    chk_edge_single: assert property (n_ev && sens == EIL_SENS_ACT && !wr_cfg
        |=> !n_ev)
        else $error("edge event lasted two cycles");
    chk_ab_block: assert property (!cfg_r[EIL_B_SKIP] && a != cfg_r[EIL_B_PA]
        && sens == EIL_SENS_LVL |-> !n_ev)
        else $error("event with wrong a level");
    chk_skip_ab: assert property (cfg_r[EIL_B_SKIP] && n_act && sens == EIL_SENS_LVL
        |-> n_ev)
        else $error("a/b not ignored");
    chk_sts_sticky: assert property (n_ev |=> sts_r ##1 (sts_r || $past(wr_sts)))
        else $error("status flag not sticky");
    chk_frac_bin: assert property (step && up && !wr_cnt && !take && !cfg_r[EIL_B_DEC]
        |=> frac_r == $past(f_up[15:0]))
        else $error("binary fraction wrong");
    chk_frac_dec: assert property (step && !wr_cnt && !take && cfg_r[EIL_B_DEC]
        && {1'b0, frac_r} < EIL_DIV_DEC && cf < EIL_DIV_DEC
        |=> {1'b0, frac_r} < EIL_DIV_DEC)
        else $error("decimal fraction out of range");

    cov_latch_clear: cover property (take && cfg_r[EIL_B_CLR]);
    cov_ramp_latch: cover property (take && cfg_r[EIL_B_LXA]);
    cov_irq_rise: cover property (!enc_irq ##1 enc_irq);
endmodule
`default_nettype wire

// file: testbench/eil_enc_model.sv
// quadrature encoder with index channel, driven by bench task calls
// assumes pclk from the bench; one channel changes per step
`timescale 1ns/1ps
`default_nettype none
module eil_enc_model
(
    input wire logic pclk,
    output logic enc_a,
    output logic enc_b,
    output logic enc_n
);
    // ==========================================
    // phase state, gray order 00 10 11 01 counts up
    logic [1:0] ph = 2'h0;
    initial
    begin
        enc_a = 1'b0;
        enc_b = 1'b0;
        enc_n = 1'b0;
    end
    // ==========================================
    // n steps up, gap cycles between steps (slow or prompt)
    task automatic step(input int n, input int gap);
        repeat (n)
        begin
            @(posedge pclk);
            ph = ph + 2'h1;
            enc_a <= ph[0] ^ ph[1];
            enc_b <= ph[1];
            repeat (gap) @(posedge pclk);
        end
    endtask
    // n steps down, gap cycles between steps
    task automatic back(input int n, input int gap);
        repeat (n)
        begin
            @(posedge pclk);
            ph = ph - 2'h1;
            enc_a <= ph[0] ^ ph[1];
            enc_b <= ph[1];
            repeat (gap) @(posedge pclk);
        end
    endtask
    // index level, then hold for gap cycles
    task automatic index(input logic lvl, input int gap);
        @(posedge pclk);
        enc_n <= lvl;
        repeat (gap) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// file: testbench/test_encoder_index_event_latch.sv
// self-checking bench for the encoder index event latch
// assumes eil_top with apb slave and the encoder model
`timescale 1ns/1ps
`default_nettype none
module test_encoder_index_event_latch
    import eil_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, enc_irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, ramp;
    wire logic enc_a, enc_b, enc_n;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [10:0] qcfg [4] = '{11'h045, 11'h047, 11'h004, 11'h04c};
    logic qexp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    eil_top eil_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
        .ramp_actual_position(ramp), .enc_irq(enc_irq));
    eil_enc_model eil_enc_model_inst (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));
    // ==========================================
    // clock, verdict, checks
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic close_out();
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ==========================================
    // apb master: setup, access until pready, release
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            chk({31'h0, pready}, 32'h1);
            close_out();
        end
        @(posedge pclk);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    task automatic pulse();
        eil_enc_model_inst.index(1'b1, 6);
        eil_enc_model_inst.index(1'b0, 6);
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        chk(32'h0, 32'h1);
        close_out();
    end
    // ==========================================
    // main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ramp = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(EIL_IDX_CFG, 32'h0);
        apb(1'b0, 6'h00, 32'h0);
        chk({31'h0, perr}, 32'h1);
        wr(EIL_IDX_LATCH, 32'h5);
        rdc(EIL_IDX_LATCH, 32'h0);
        wr(EIL_IDX_CFG, 32'h05c);
        eil_enc_model_inst.step(3, 4);
        pulse();
        rdc(EIL_IDX_LATCH, 32'h3);
        rdc(EIL_IDX_CNT, 32'h3);
        rdc(EIL_IDX_STS, 32'h1);
        chk({31'h0, enc_irq}, 32'h0);
        wr(EIL_IDX_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, enc_irq}, 32'h1);
        wr(EIL_IDX_STS, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, enc_irq}, 32'h0);
        wr(EIL_IDX_CFG, 32'h15c);
        eil_enc_model_inst.step(2, 4);
        pulse();
        rdc(EIL_IDX_LATCH, 32'h5);
        rdc(EIL_IDX_CNT, 32'h0);
        ramp <= 32'h00c0_ffee;
        wr(EIL_IDX_CFG, 32'h25c);
        pulse();
        rdc(EIL_IDX_XLATCH, 32'h00c0_ffee);
        wr(EIL_IDX_CNT, 32'h7);
        wr(EIL_IDX_CFG, 32'h06c);
        pulse();
        rdc(EIL_IDX_LATCH, 32'h7);
        wr(EIL_IDX_CNT, 32'h9);
        pulse();
        rdc(EIL_IDX_LATCH, 32'h7);
        wr(EIL_IDX_CFG, 32'h06c);
        pulse();
        rdc(EIL_IDX_LATCH, 32'h9);
        for (int c = 0; c < 4; c++)
        begin
            wr(EIL_IDX_CFG, {24'h0, c[1:0], 6'h0c});
            wr(EIL_IDX_STS, 32'h1);
            eil_enc_model_inst.index(1'b1, 6);
            rdc(EIL_IDX_STS, {31'h0, c != 2});
            wr(EIL_IDX_STS, 32'h1);
            eil_enc_model_inst.index(1'b0, 6);
            rdc(EIL_IDX_STS, {31'h0, c != 1});
        end
        wr(EIL_IDX_CFG, 32'h048);
        wr(EIL_IDX_STS, 32'h1);
        eil_enc_model_inst.index(1'b1, 6);
        rdc(EIL_IDX_STS, 32'h0);
        eil_enc_model_inst.index(1'b0, 6);
        rdc(EIL_IDX_STS, 32'h1);
        for (int q = 0; q < 4; q++)
        begin
            wr(EIL_IDX_CFG, {21'h0, qcfg[q]});
            wr(EIL_IDX_STS, 32'h1);
            pulse();
            rdc(EIL_IDX_STS, {31'h0, qexp[q]});
        end
        wr(EIL_IDX_CONST, 32'h0000_1388);
        wr(EIL_IDX_CFG, 32'h400);
        wr(EIL_IDX_CNT, 32'h0);
        eil_enc_model_inst.step(2, 4);
        rdc(EIL_IDX_CNT, 32'h1);
        wr(EIL_IDX_CFG, 32'h0);
        wr(EIL_IDX_CNT, 32'h0);
        eil_enc_model_inst.step(2, 4);
        rdc(EIL_IDX_CNT, 32'h0);
        wr(EIL_IDX_CONST, 32'h0000_8000);
        eil_enc_model_inst.step(2, 4);
        rdc(EIL_IDX_CNT, 32'h1);
        wr(EIL_IDX_CNT, 32'h5);
        wr(EIL_IDX_CONST, 32'h0001_0000);
        eil_enc_model_inst.back(2, 4);
        rdc(EIL_IDX_CNT, 32'h3);
        close_out();
    end
endmodule
`default_nettype wire
